//--- src/tpm_pkg.sv
// shared constants for the transceiver power-mode and configuration block
package tpm_pkg;

	// ==================================================================
	// register addresses
	localparam logic [4:0] ADR_CFG1 = 5'h00;
	localparam logic [4:0] ADR_CFG2 = 5'h01;
	localparam logic [4:0] ADR_CFG3 = 5'h02;
	localparam logic [4:0] NUM_CR = 5'h08;
	localparam logic [4:0] ADR_STAT = 5'h10;

	// ==================================================================
	// reset values of the eight control registers
	localparam logic [7:0] CR1_RST = 8'h80;
	localparam logic [7:0] CR2_RST = 8'hA8;
	localparam logic [7:0] CR3_RST = 8'h7B;
	localparam logic [7:0] CR4_RST = 8'h60;
	localparam logic [7:0] CR5_RST = 8'h4B;
	localparam logic [7:0] CR6_RST = 8'hA0;
	localparam logic [7:0] CR7_RST = 8'h14;
	localparam logic [7:0] CR8_RST = 8'h50;
	localparam logic [7:0][7:0] CR_RST = {CR8_RST, CR7_RST, CR6_RST,
		CR5_RST, CR4_RST, CR3_RST, CR2_RST, CR1_RST};

	// ==================================================================
	// field positions
	localparam int CR1_IR_HI = 7;
	localparam int CR1_IR_LO = 6;
	localparam int CR1_RANGE = 5;
	localparam int CR1_BAND = 4;
	localparam int CR1_OPM_HI = 3;
	localparam int CR1_OPM_LO = 1;
	localparam int CR1_TRANSP = 0;
	localparam int CR2_FR_HI = 7;
	localparam int CR2_FR_LO = 1;
	localparam int CR2_MASK = 0;
	localparam int CR3_FR_HI = 7;
	localparam int CR3_FR_LIM = 4;
	localparam int CR3_FR_LO = 2;
	localparam int CR3_CLK_EN = 1;
	localparam int CR3_CLK_ON = 0;
	localparam int ST_BTN = 7;
	localparam int ST_PWR = 2;
	localparam int ST_SUP = 1;

	// ==================================================================
	// modes, commands, thresholds, tuning limits
	localparam logic [2:0] OPM_IDLE = 3'h0;
	localparam logic [2:0] OPM_TX = 3'h1;
	localparam logic [2:0] OPM_RXP = 3'h2;
	localparam logic [2:0] OPM_RX = 3'h3;
	localparam logic [2:0] CMD_RD_REG = 3'h0;
	localparam logic [2:0] CMD_WR_REG = 3'h1;
	localparam logic [2:0] CMD_RD_BUF = 3'h2;
	localparam logic [2:0] CMD_WR_BUF = 3'h3;
	localparam logic [2:0] CMD_OFF = 3'h4;
	localparam int LVL_W = 5;
	localparam logic [3:0][4:0] THR = {5'h0C, 5'h04, 5'h02, 5'h01};
	localparam logic [2:0] TUNE_BASE_HI = 3'h3;
	localparam logic [12:0] TUNE_MIN = 13'h0C00;
	localparam logic [12:0] TUNE_MAX = 13'h0FFF;

	// ==================================================================
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int XTO_START_NS = 2000;
	localparam int XTO_CYC = (XTO_START_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;
	localparam int XW = $clog2(XTO_CYC + 1);

	typedef enum logic [1:0] {
		PW_OFF = 2'h0,
		PW_IDLE = 2'h1
	} tpm_pwr_t;

endpackage

//--- src/tpm_sync.sv
// two-flop synchroniser for a group of independent levels
`timescale 1ns/1ps
module tpm_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// levels
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_r;
	logic [W-1:0] q_r;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_r <= RST_VAL;
			q_r <= RST_VAL;
		end else begin
			meta_r <= d_i;
			q_r <= meta_r;
		end
	end

	assign q_o = q_r;
endmodule // tpm_sync

//--- src/tpm_link.sv
// serial frame shifter on the host's serial clock
`timescale 1ns/1ps
module tpm_link (
	// clock and reset
	input wire logic sck_i,
	input wire logic rst_i,
	// pins
	input wire logic cs_n_i,
	input wire logic sdi_i,
	output logic sdo_o,
	// towards the core domain
	input wire logic [7:0] rd_data_i,
	output logic [7:0] cmd_o,
	output logic [7:0] dat_o,
	output logic tgl_o
);
	typedef struct packed {
		logic [3:0] cnt;
		logic [14:0] sh;
		logic [7:0] so;
		logic [7:0] cmd;
		logic [7:0] dat;
		logic tgl;
	} tpm_lk_t;

	tpm_lk_t lk_r;
	tpm_lk_t lk_nxt;

	// ==================================================================
	// frames are exactly sixteen clocks; sck only runs inside a frame
	always_comb begin
		lk_nxt = lk_r;
		if (!cs_n_i) begin
			lk_nxt.cnt = lk_r.cnt + 4'h1;
			lk_nxt.sh = {lk_r.sh[13:0], sdi_i};
			if (lk_r.cnt == 4'h0)
				lk_nxt.so = {rd_data_i[6:0], 1'b0};
			else
				lk_nxt.so = {lk_r.so[6:0], 1'b0};
			// cmd and dat stay frozen until the next frame ends
			if (lk_r.cnt == 4'hF) begin
				lk_nxt.cmd = lk_r.sh[14:7];
				lk_nxt.dat = {lk_r.sh[6:0], sdi_i};
				lk_nxt.tgl = ~lk_r.tgl;
			end
		end
	end

	always_ff @(posedge sck_i or posedge rst_i) begin
		if (rst_i)
			lk_r <= '0;
		else
			lk_r <= lk_nxt;
	end

	// read word is held still by the core between frames
	assign sdo_o = (lk_r.cnt == 4'h0) ? rd_data_i[7] : lk_r.so[7];
	assign cmd_o = lk_r.cmd;
	assign dat_o = lk_r.dat;
	assign tgl_o = lk_r.tgl;
endmodule // tpm_link

//--- src/tpm_regs.sv
// power-mode sequencing, control registers, status and data buffer
`timescale 1ns/1ps
// ==================================================================
// Overview of operation
// - wake high or button low leaves off
// - wake-up raises irq; only wake pin sets cause flag
// - serial accesses ignored while off
// - off command returns idle to off
// - power-up loads defaults, sets supply flag
// - supply flag clears after supply, xto, read
// - host clock needs supply and xto start
// - supply loss with pins idle enters off
// - sixteen byte buffer, eight control registers
// - status register at address sixteen
// - contents kept when active, lost when off
// - receive irq at level threshold or error
// - transmit irq at remaining level or empty
// - range bit limits tuning word span
// - band select bit picks band
// - mode field selects idle, tx, rx
// - transparent bit bypasses buffer via pins
// - register two holds tuning low part
// - mask bit gates bit-check irq
// - tuning word is low plus high part
// - status read clears wake flag and irq
// - wake flag forces clock-on bit
module tpm_regs
	import tpm_pkg::*;
#(
	parameter int BUF_DEPTH = 16,
	parameter int AW = $clog2(BUF_DEPTH)
) (
	// clocks and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	input wire logic sck_i,
	// serial interface pins
	input wire logic cs_n_i,
	input wire logic serial_in_mod_data_i,
	output logic serial_out_mod_data_o,
	// wake and supply pins
	input wire logic wake_input_high_i,
	input wire logic button_wake_low_n_i,
	input wire logic supply_good_i,
	// transceiver datapath
	input wire logic [LVL_W-1:0] buffer_level_i,
	input wire logic rx_error_i,
	input wire logic bitcheck_ok_i,
	input wire logic dp_we_i,
	input wire logic [AW-1:0] dp_addr_i,
	input wire logic [7:0] dp_wdata_i,
	input wire logic rx_mod_data_i,
	output logic [7:0] dp_rdata_o,
	output logic tx_mod_data_o,
	// mode and configuration
	output logic powered_o,
	output logic host_clk_en_o,
	output logic irq_o,
	output logic [12:0] synth_tuning_word_o,
	output logic band_select_o,
	output logic tx_mode_o,
	output logic rx_polled_o,
	output logic rx_cont_o,
	output logic transparent_o
);

	typedef struct packed {
		tpm_pwr_t pw;
		logic [7:0][7:0] cr;
		logic [BUF_DEPTH-1:0][7:0] mem;
		logic pflag;
		logic sflag;
		logic irq;
		logic [7:0] rd;
		logic [7:0] dprd;
		logic [XW-1:0] xcnt;
		logic xdone;
		logic tg;
		logic sup_d;
		logic btn_d;
		logic [LVL_W-1:0] lvl;
	} tpm_st_t;

	localparam tpm_st_t ST_RST = '{pw: PW_OFF, cr: CR_RST, sflag: 1'b1,
		default: '0};

	tpm_st_t st_r;
	tpm_st_t st_nxt;
	logic [4:0] pin_s;
	logic wake_s;
	logic btn_s;
	logic sup_s;
	logic sdi_s;
	logic tgl_s;
	logic tgl_raw;
	logic lk_sdo;
	logic [7:0] f_cmd;
	logic [7:0] f_dat;
	logic [2:0] md_w;
	logic [12:0] tune_hi;

	// reserved codes fall back to idle so nothing starts
	function automatic logic [2:0] opm_of(input logic [7:0] c1);
		logic [2:0] m;
		m = c1[CR1_OPM_HI:CR1_OPM_LO];
		opm_of = m[2] ? OPM_IDLE : m;
	endfunction

	function automatic logic [LVL_W-1:0] thr_of(input logic [7:0] c1);
		thr_of = THR[c1[CR1_IR_HI:CR1_IR_LO]];
	endfunction

	// ==================================================================
	// link domain and crossings
	tpm_link u_link (
		.sck_i(sck_i),
		.rst_i(rst_i),
		.cs_n_i(cs_n_i),
		.sdi_i(serial_in_mod_data_i),
		.sdo_o(lk_sdo),
		.rd_data_i(st_r.rd),
		.cmd_o(f_cmd),
		.dat_o(f_dat),
		.tgl_o(tgl_raw)
	);

	// button idles high, so its stages reset high to avoid a false wake
	tpm_sync #(
		.W(5),
		.RST_VAL(5'h02)
	) u_sync (
		.clk_i(mclk_i),
		.rst_i(rst_i),
		.d_i({tgl_raw, serial_in_mod_data_i, supply_good_i,
			button_wake_low_n_i, wake_input_high_i}),
		.q_o(pin_s)
	);

	assign wake_s = pin_s[0];
	assign btn_s = ~pin_s[1];
	assign sup_s = pin_s[2];
	assign sdi_s = pin_s[3];
	assign tgl_s = pin_s[4];
	assign md_w = opm_of(st_r.cr[0]);

	// ==================================================================
	// next-state logic
	always_comb begin
		logic fr;
		logic [2:0] op;
		logic [4:0] ad;
		logic [LVL_W-1:0] th;
		logic rxm;
		logic txm;
		logic ev;
		logic [7:0] stat;
		fr = tgl_s ^ st_r.tg;
		op = f_cmd[7:5];
		ad = f_cmd[4:0];
		th = thr_of(st_r.cr[0]);
		rxm = (md_w == OPM_RXP) || (md_w == OPM_RX);
		txm = (md_w == OPM_TX);
		ev = 1'b0;
		stat = 8'h00;
		stat[ST_BTN] = btn_s;
		stat[ST_PWR] = st_r.pflag;
		stat[ST_SUP] = st_r.sflag;
		st_nxt = st_r;
		st_nxt.tg = tgl_s;
		st_nxt.sup_d = sup_s;
		st_nxt.btn_d = btn_s;
		st_nxt.lvl = buffer_level_i;
		st_nxt.dprd = st_r.mem[dp_addr_i];
		case (st_r.pw)
		PW_OFF: begin
			// nothing survives power-down; frames are dropped here
			st_nxt.cr = CR_RST;
			st_nxt.mem = '0;
			st_nxt.sflag = 1'b1;
			st_nxt.pflag = 1'b0;
			st_nxt.irq = 1'b0;
			st_nxt.xcnt = '0;
			st_nxt.xdone = 1'b0;
			if (wake_s || btn_s) begin
				st_nxt.pw = PW_IDLE;
				st_nxt.irq = 1'b1;
				st_nxt.pflag = wake_s;
			end
		end
		default: begin
			// start-up restarts after a supply dip that the pins rode out
			if (!sup_s) begin
				st_nxt.xcnt = '0;
				st_nxt.xdone = 1'b0;
			end else if (!st_r.xdone) begin
				st_nxt.xcnt = st_r.xcnt + XW'(1);
				st_nxt.xdone = (st_r.xcnt == XW'(XTO_CYC - 1));
			end
			if (dp_we_i)
				st_nxt.mem[dp_addr_i] = dp_wdata_i;
			if (fr) begin
				if (op == CMD_RD_REG) begin
					if (ad < NUM_CR) begin
						st_nxt.rd = st_r.cr[ad[2:0]];
					end else if (ad == ADR_STAT) begin
						st_nxt.rd = stat;
						st_nxt.pflag = 1'b0;
						st_nxt.irq = 1'b0;
						if (sup_s && st_r.xdone)
							st_nxt.sflag = 1'b0;
					end else begin
						st_nxt.rd = 8'h00;
					end
				end else if (op == CMD_WR_REG) begin
					if (ad < NUM_CR)
						st_nxt.cr[ad[2:0]] = f_dat;
				end else if (op == CMD_RD_BUF) begin
					st_nxt.rd = st_r.mem[ad[AW-1:0]];
				end else if (op == CMD_WR_BUF) begin
					st_nxt.mem[ad[AW-1:0]] = f_dat;
				end else if (op == CMD_OFF) begin
					// ignored unless idle with both wake pins released
					if (md_w == OPM_IDLE && !wake_s && !btn_s)
						st_nxt.pw = PW_OFF;
				end
			end
			// supply loss only powers down if no pin holds it up
			if (st_r.sup_d && !sup_s && !wake_s && !btn_s)
				st_nxt.pw = PW_OFF;
			// after the write path so a host write cannot undo it
			if (st_r.pflag || (btn_s && !st_r.btn_d) ||
				(rxm && bitcheck_ok_i))
				st_nxt.cr[ADR_CFG3[2:0]][CR3_CLK_ON] = 1'b1;
			// events come last: a set beats a same-cycle clear
			if (rxm) begin
				ev = rx_error_i ||
					(buffer_level_i == th && st_r.lvl < th);
				if (bitcheck_ok_i && !st_r.cr[ADR_CFG2[2:0]][CR2_MASK])
					ev = 1'b1;
			end else if (txm) begin
				ev = (buffer_level_i == th && st_r.lvl > th) ||
					(buffer_level_i == '0 && st_r.lvl != '0);
			end
			if (ev || (btn_s && !st_r.btn_d))
				st_nxt.irq = 1'b1;
		end
		endcase
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i)
			st_r <= ST_RST;
		else
			st_r <= st_nxt;
	end

	// ==================================================================
	// outputs
	// range bit 0 pins the top bits so the word stays in its window
	assign tune_hi = st_r.cr[0][CR1_RANGE] ?
		{st_r.cr[2][CR3_FR_HI:CR3_FR_LO], 7'h00} :
		{TUNE_BASE_HI, st_r.cr[2][CR3_FR_LIM:CR3_FR_LO], 7'h00};
	assign synth_tuning_word_o = tune_hi |
		{6'h00, st_r.cr[1][CR2_FR_HI:CR2_FR_LO]};
	assign band_select_o = st_r.cr[0][CR1_BAND];
	assign tx_mode_o = (md_w == OPM_TX);
	assign rx_polled_o = (md_w == OPM_RXP);
	assign rx_cont_o = (md_w == OPM_RX);
	assign transparent_o = st_r.cr[0][CR1_TRANSP];
	assign tx_mod_data_o = transparent_o && tx_mode_o && sdi_s;
	assign serial_out_mod_data_o = transparent_o ? rx_mod_data_i :
		lk_sdo;
	assign dp_rdata_o = st_r.dprd;
	assign powered_o = (st_r.pw == PW_IDLE);
	assign irq_o = st_r.irq;
	assign host_clk_en_o = powered_o && sup_s && st_r.xdone &&
		st_r.cr[2][CR3_CLK_EN] && st_r.cr[2][CR3_CLK_ON];

	// ==================================================================
	// checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	off_wake_a: assert property (
		st_r.pw == PW_OFF && (wake_s || btn_s)
		|=> st_r.pw == PW_IDLE && irq_o
	) else $error("wake pin did not leave off");

	wake_flag_a: assert property (
		st_r.pw == PW_OFF && wake_s |=> st_r.pflag && st_r.sflag
	) else $error("wake flag not set on wake-up");

	off_ignore_a: assert property (
		st_r.pw == PW_OFF && tgl_s != st_r.tg |=> $stable(st_r.rd)
	) else $error("serial access served while off");

	off_cmd_a: assert property (
		st_r.pw == PW_IDLE && tgl_s != st_r.tg && f_cmd[7:5] == CMD_OFF
		&& md_w == OPM_IDLE && !wake_s && !btn_s |=> st_r.pw == PW_OFF
	) else $error("off command not obeyed");

	off_keep_a: assert property (
		st_r.pw == PW_IDLE && f_cmd[7:5] == CMD_OFF && (wake_s || btn_s)
		|=> st_r.pw == PW_IDLE
	) else $error("off command taken with wake pin asserted");

	dflt_load_a: assert property (
		st_r.pw == PW_OFF |=> st_r.cr == CR_RST && st_r.sflag
	) else $error("defaults not loaded at power-up");

	sflag_hold_a: assert property (
		st_r.pw == PW_IDLE && st_r.sflag && !st_r.xdone |=> st_r.sflag
	) else $error("supply flag cleared too early");

	clk_gate_a: assert property (
		host_clk_en_o |-> st_r.xcnt == XW'(XTO_CYC) && $past(sup_s)
	) else $error("host clock before oscillator start-up");

	sup_loss_a: assert property (
		st_r.pw == PW_IDLE && st_r.sup_d && !sup_s && !wake_s && !btn_s
		|=> st_r.pw == PW_OFF
	) else $error("supply loss did not power down");

	stat_clr_a: assert property (
		st_r.pw == PW_IDLE && tgl_s != st_r.tg &&
		f_cmd == {CMD_RD_REG, ADR_STAT} |=> !st_r.pflag
	) else $error("status read left wake flag set");

	rx_irq_a: assert property (
		st_r.pw == PW_IDLE && rx_cont_o && rx_error_i |=> irq_o
	) else $error("receive error raised no interrupt");

	tune_rng_a: assert property (
		!st_r.cr[0][CR1_RANGE] |-> synth_tuning_word_o >= TUNE_MIN &&
		synth_tuning_word_o <= TUNE_MAX
	) else $error("tuning word outside narrow range");

	clk_on_a: assert property (
		st_r.pflag && st_r.pw == PW_IDLE |=> st_r.cr[2][CR3_CLK_ON]
	) else $error("clock-on bit not forced");

	rsvd_mode_a: assert property (
		st_r.cr[0][CR1_OPM_HI] |-> !tx_mode_o && !rx_polled_o &&
		!rx_cont_o
	) else $error("reserved mode started activity");

endmodule // tpm_regs

//--- bench/tpm_host.sv
// host-side serial master model for the configuration block
`timescale 1ns/1ps
module tpm_host (
	// serial pins
	output logic sck_o,
	output logic cs_n_o,
	output logic sdi_o,
	input wire logic sdo_i
);
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		sdi_o = 1'b0;
	end

	// ========
	// frame
	// sck idles low outside frames; sdo is sampled before each of the first eight rises
	task automatic xfer(input logic [7:0] cmd, input logic [7:0] dat,
		output logic [7:0] q);
		logic [15:0] w;
		w = {cmd, dat};
		cs_n_o = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			sdi_o = w[i];
			#6;
			if (i > 7)
				q[i-8] = sdo_i;
			sck_o = 1'b1;
			#6;
			sck_o = 1'b0;
		end
		#6;
		cs_n_o = 1'b1;
		// idle data line changes so a stale bit is never mistaken for data
		sdi_o = ~sdi_o;
	endtask

	// transparent mode: the data line carries modulation between frames
	task automatic set_sdi(input logic b);
		sdi_o = b;
	endtask
endmodule // tpm_host

//--- bench/transceiver_power_mode_config_regs_bench.sv
// self-checking bench for the power-mode and configuration block
`timescale 1ns/1ps
`define CHK(g, e) begin \
	n_checks++; \
	if ((g) !== (e)) begin \
		failures++; \
		$display("unexpected at %0t: got %0h exp %0h", $time, g, e); \
	end \
end
module transceiver_power_mode_config_regs_bench
	import tpm_pkg::*;
;
	logic mclk_i, rst_i, sck, cs_n, sdi, sdo, wake, btn_n, sup;
	logic rxe, bok, dwe, rxm, pwr, clk_en, irq, band;
	logic tx_o, rxp_o, rxc_o, tr_o, txd;
	logic [4:0] lvl;
	logic [3:0] dad;
	logic [7:0] dwd, drd, rdw, v, s;
	logic [12:0] tw;
	logic [7:0] cr [8];
	int failures, n_checks, hi;

	tpm_host host (.sck_o(sck), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo));
	tpm_regs uut (.mclk_i(mclk_i), .rst_i(rst_i), .sck_i(sck),
		.cs_n_i(cs_n), .serial_in_mod_data_i(sdi),
		.serial_out_mod_data_o(sdo), .wake_input_high_i(wake),
		.button_wake_low_n_i(btn_n), .supply_good_i(sup),
		.buffer_level_i(lvl), .rx_error_i(rxe), .bitcheck_ok_i(bok),
		.dp_we_i(dwe), .dp_addr_i(dad), .dp_wdata_i(dwd),
		.rx_mod_data_i(rxm), .dp_rdata_o(drd), .tx_mod_data_o(txd),
		.powered_o(pwr), .host_clk_en_o(clk_en), .irq_o(irq),
		.synth_tuning_word_o(tw), .band_select_o(band), .tx_mode_o(tx_o),
		.rx_polled_o(rxp_o), .rx_cont_o(rxc_o), .transparent_o(tr_o));

	// ========
	// helpers
	function automatic logic [7:0] lfsr(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction
	task automatic tick(input int n);
		repeat (n) @(negedge mclk_i);
	endtask
	// gap after each frame lets the crossing settle
	task automatic fr(input logic [2:0] op, input logic [4:0] a,
		input logic [7:0] d);
		host.xfer({op, a}, d, rdw);
		tick(10);
	endtask
	// read data comes back in the following frame
	task automatic rd(input logic [2:0] op, input logic [4:0] a);
		fr(op, a, 8'h00);
		fr(CMD_RD_REG, ADR_CFG1, 8'h00);
		v = rdw;
	endtask
	task automatic wake_up(input logic by_pin);
		if (by_pin)
			wake = 1'b1;
		else
			btn_n = 1'b0;
		tick(6);
		`CHK(pwr, 1'b1)
		`CHK(irq, 1'b1)
		`CHK(clk_en, 1'b0)
		wake = 1'b0;
		tick(250);
		`CHK(clk_en, 1'b1)
	endtask
	task automatic wrap_up;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ========
	// clock and watchdog
	initial begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end
	initial begin
		#500000;
		failures++;
		wrap_up();
	end

	// ========
	// sequence
	initial begin
		{rst_i, sup, btn_n} = 3'h3;
		{wake, rxe, bok, dwe, rxm} = 5'h00;
		lvl = 5'h00;
		dad = 4'h0;
		dwd = 8'h00;
		s = 8'h51;
		// a real rising edge once every process waits: the link has no clock
		#1;
		rst_i = 1'b1;
		tick(5);
		rst_i = 1'b0;
		`CHK({pwr, irq, clk_en}, 3'h0)
		fr(CMD_WR_REG, ADR_CFG2, 8'h11);
		wake_up(1'b1);
		rd(CMD_RD_REG, ADR_CFG2);
		`CHK(v, CR2_RST)
		fr(CMD_WR_REG, ADR_CFG3, 8'h7A);
		rd(CMD_RD_REG, ADR_CFG3);
		`CHK(v, 8'h7B)
		rd(CMD_RD_REG, ADR_STAT);
		`CHK(v, 8'h06)
		`CHK(irq, 1'b0)
		rd(CMD_RD_REG, ADR_STAT);
		`CHK(v, 8'h00)
		for (int m = 0; m < 8; m++) begin
			for (int a = 0; a < 8; a++) begin
				s = lfsr(s);
				cr[a] = s;
				if (a == 0)
					cr[0][3:0] = {m[2:0], 1'b0};
				fr(CMD_WR_REG, 5'(a), cr[a]);
			end
			for (int a = 0; a < 8; a++) begin
				rd(CMD_RD_REG, 5'(a));
				`CHK(v, cr[a])
			end
			hi = cr[0][5] ? cr[2][7:2] * 128 : 3072 + cr[2][4:2] * 128;
			`CHK(tw, 13'(hi + cr[1][7:1]))
			`CHK(band, cr[0][4])
			`CHK({tx_o, rxp_o, rxc_o}, 3'(m < 4 ? 8 >> m : 0))
			`CHK(clk_en, cr[2][1] & cr[2][0])
		end
		fr(CMD_WR_REG, 5'h09, 8'hFF);
		rd(CMD_RD_REG, 5'h09);
		`CHK(v, 8'h00)
		s = lfsr(s);
		{dwe, dad, dwd} = {1'b1, 4'h5, s};
		tick(1);
		dwe = 1'b0;
		rd(CMD_RD_BUF, 5'h05);
		`CHK(v, s)
		fr(CMD_WR_BUF, 5'h0F, ~s);
		dad = 4'hF;
		tick(2);
		`CHK(drd, ~s)
		fr(CMD_WR_REG, ADR_CFG1, 8'h03);
		for (int b = 0; b < 2; b++) begin
			rxm = b[0];
			host.set_sdi(~b[0]);
			tick(2);
			`CHK({tr_o, sdo, txd}, {1'b1, b[0], ~b[0]})
		end
		for (int k = 0; k < 4; k++) begin
			fr(CMD_WR_REG, ADR_CFG1, {2'(k), 6'h06});
			lvl = 5'h00;
			rd(CMD_RD_REG, ADR_STAT);
			lvl = THR[k] - 5'h01;
			tick(5);
			`CHK(irq, 1'b0)
			lvl = THR[k];
			tick(5);
			`CHK(irq, 1'b1)
		end
		rd(CMD_RD_REG, ADR_STAT);
		rxe = 1'b1;
		tick(1);
		rxe = 1'b0;
		tick(4);
		`CHK(irq, 1'b1)
		for (int k = 1; k >= 0; k--) begin
			fr(CMD_WR_REG, ADR_CFG2, {7'h54, k[0]});
			rd(CMD_RD_REG, ADR_STAT);
			bok = 1'b1;
			tick(1);
			bok = 1'b0;
			tick(4);
			`CHK(irq, ~k[0])
		end
		fr(CMD_WR_REG, ADR_CFG1, 8'h82);
		lvl = 5'h06;
		rd(CMD_RD_REG, ADR_STAT);
		lvl = 5'h05;
		tick(5);
		`CHK(irq, 1'b0)
		lvl = 5'h04;
		tick(5);
		`CHK(irq, 1'b1)
		rd(CMD_RD_REG, ADR_STAT);
		`CHK(irq, 1'b0)
		lvl = 5'h00;
		tick(5);
		`CHK(irq, 1'b1)
		fr(CMD_WR_REG, ADR_CFG1, 8'h80);
		wake = 1'b1;
		fr(CMD_OFF, 5'h00, 8'h00);
		`CHK(pwr, 1'b1)
		wake = 1'b0;
		fr(CMD_OFF, 5'h00, 8'h00);
		`CHK(pwr, 1'b0)
		wake_up(1'b0);
		rd(CMD_RD_REG, ADR_CFG1);
		`CHK(v, CR1_RST)
		rd(CMD_RD_REG, ADR_STAT);
		`CHK(v, 8'h82)
		btn_n = 1'b1;
		tick(5);
		sup = 1'b0;
		tick(6);
		`CHK(pwr, 1'b0)
		wrap_up();
	end
endmodule // transceiver_power_mode_config_regs_bench
